// >>> fsrw_consts.svh
// constants for the flash self read/write controller
`ifndef FSRW_CONSTS_SVH
`define FSRW_CONSTS_SVH
`define FSRW_OFS_CTRL      8'h93
`define FSRW_OFS_UNLOCK    8'h94
`define FSRW_OFS_DATA_LO   8'h95
`define FSRW_OFS_DATA_HI   8'h96
`define FSRW_OFS_ADDR_LO   8'h97
`define FSRW_OFS_ADDR_HI   8'h98
`define FSRW_BIT_RD        0
`define FSRW_BIT_WR        1
`define FSRW_BIT_WEN       2
`define FSRW_CTRL_TOP      8'h80
`define FSRW_KEY1          8'h55
`define FSRW_KEY2          8'hAA
`define FSRW_MEM_WORDS     2048
`define FSRW_AW            11
`define FSRW_DW            14
`define FSRW_LAST_OFS      2'h3
`define FSRW_ERASE_MASK    11'h7F0
`define FSRW_PROG_TIME_US  4000
`define FSRW_CLK_MHZ       25
`define FSRW_SETUP_CYC     2'h2
`define FSRW_RD_FETCH      2'h0
`define FSRW_RD_DROP       2'h1
`define FSRW_ERASE_WORDS   16
`define FSRW_BLK_WORDS     4
`endif

// >>> fsrw_pkg.sv
// types for the flash self read/write controller
package fsrw_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } fsrw_bus_type;
  typedef enum logic [1:0] {
    FSRW_IDLE,
    FSRW_SETUP,
    FSRW_PROG
  } fsrw_state_type;
endpackage

// >>> fsrw_array.sv
// flash array: 2K x 14 words, 16-word erase and 4-word program
`include "fsrw_consts.svh"
module fsrw_array (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire logic [`FSRW_AW-1:0]   rd_addr,
  input  wire logic                  rd_en,
  output logic      [`FSRW_DW-1:0]   rd_data,
  input  wire logic [`FSRW_AW-1:0]   blk_addr,
  input  wire logic                  erase,
  input  wire logic                  prog,
  input  wire logic [4*`FSRW_DW-1:0] prog_data
);
  logic [`FSRW_DW-1:0] mem [0:`FSRW_MEM_WORDS-1];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

  // erased cells read all ones
  always_ff @(posedge clk) begin
    for (int i = 0; i < `FSRW_ERASE_WORDS; i++) begin
      if (erase) begin
        mem[(blk_addr & `FSRW_ERASE_MASK) | 11'(i)] <= '1;
      end
    end
    for (int j = 0; j < `FSRW_BLK_WORDS; j++) begin
      if (prog) begin
        mem[{blk_addr[`FSRW_AW-1:2], 2'(j)}] <= prog_data[j*`FSRW_DW +: `FSRW_DW];
      end
    end
  end
endmodule

// >>> fsrw_unlock.sv
// unlock detector: 55h then AAh written to the key port, with no other write but to control between
`include "fsrw_consts.svh"
module fsrw_unlock (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       key_we,
  input  wire logic       other_we,
  input  wire logic [7:0] wdata,
  output logic            unlocked
);
  logic seen55_r;
  logic unlocked_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      seen55_r <= 1'b0;
    end else if (key_we) begin
      seen55_r <= (wdata == `FSRW_KEY1);
    end else if (other_we) begin
      seen55_r <= 1'b0;
    end
  end

  // armed only by the second key and lost on any write other than to the control offset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      unlocked_r <= 1'b0;
    end else if (key_we) begin
      unlocked_r <= seen55_r && (wdata == `FSRW_KEY2);
    end else if (other_we) begin
      unlocked_r <= 1'b0;
    end
  end

  assign unlocked = unlocked_r;
endmodule

// >>> fsrw_ctrl.sv
// flash self read/write controller top
//
// Operation
// - array read happens in the second cycle; that instruction is discarded; the array is fetched in the first and lands as the second ends
// - read data lands in data registers next cycle and is held
// - read trigger self-clears after two cycles; software cannot clear it
// - write trigger settable only; hardware clears it when write completes
// - write-allow low inhibits every write to memory
// - writes go in aligned blocks of four sequential words
// - trigger at offset 11 erases sixteen words and programs the buffer
// - block write stays within its aligned block
// - first three words only fill the buffer without stalling
// - final word halts execution for about 4 ms, clocks keep running
// - execution resumes at the third instruction after the trigger
// - words are writable only in unprotected segments; the 16-word erase still clears protected words in its row
// - control bit 7 reads one, bits 6 to 3 read zero
// - high data register holds six top data bits; bits 7,6 read zero
// - high address register holds three top address bits; rest zero
// - unlock port has no storage and reads all zeros
// - write-allow is cleared at power-up
// - program memory is 2K words of 14 bits
//
// The address-and-strobe port was decided locally.
`include "fsrw_consts.svh"
module fsrw_ctrl #(
  parameter int PROG_CYC = (`FSRW_PROG_TIME_US * `FSRW_CLK_MHZ)
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire fsrw_pkg::fsrw_bus_type bus,
  output logic [7:0]                rdata,
  input  wire logic [`FSRW_AW-1:0]  protect_lo,
  input  wire logic [`FSRW_AW-1:0]  protect_hi,
  input  wire logic                 protect_en,
  output logic                      discard_instr,
  output logic                      core_halt
);
  ////////////////////////////////////////////////////////////////////////////
  // decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    return a == ofs;
  endfunction

  logic wr_ctrl;
  logic wr_key;
  logic wr_dlo;
  logic wr_dhi;
  logic wr_alo;
  logic wr_ahi;
  assign wr_ctrl = bus.we && hit(bus.addr, `FSRW_OFS_CTRL);
  assign wr_key  = bus.we && hit(bus.addr, `FSRW_OFS_UNLOCK);
  assign wr_dlo  = bus.we && hit(bus.addr, `FSRW_OFS_DATA_LO);
  assign wr_dhi  = bus.we && hit(bus.addr, `FSRW_OFS_DATA_HI);
  assign wr_alo  = bus.we && hit(bus.addr, `FSRW_OFS_ADDR_LO);
  assign wr_ahi  = bus.we && hit(bus.addr, `FSRW_OFS_ADDR_HI);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [7:0]          addr_low_reg_r;
  logic [2:0]          addr_high_reg_r;
  logic [7:0]          data_low_reg_r;
  logic [5:0]          data_high_reg_r;
  logic                write_allow_r;
  logic                rd_bit_r;
  logic                wr_bit_r;
  logic [1:0]          rd_cnt_r;
  logic [`FSRW_AW-1:0] addr;
  logic [`FSRW_DW-1:0] arr_rdata;
  logic                arr_rd;
  logic                rd_land_r;
  logic                unlocked;
  logic                wr_fire;
  logic                wr_done;
  logic                erase;
  logic                prog;
  fsrw_pkg::fsrw_state_type state_r;

  // 11-bit word address; bits above 2K are not stored
  assign addr = {addr_high_reg_r, addr_low_reg_r};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_low_reg_r <= '0;
    end else if (wr_alo) begin
      addr_low_reg_r <= bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_high_reg_r <= '0;
    end else if (wr_ahi) begin
      addr_high_reg_r <= bus.wdata[2:0];
    end
  end

  // array read wins over a software write in the landing cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_low_reg_r <= '0;
    end else if (rd_land_r) begin
      data_low_reg_r <= arr_rdata[7:0];
    end else if (wr_dlo) begin
      data_low_reg_r <= bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_high_reg_r <= '0;
    end else if (rd_land_r) begin
      data_high_reg_r <= arr_rdata[13:8];
    end else if (wr_dhi) begin
      data_high_reg_r <= bus.wdata[5:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      write_allow_r <= 1'b0;
    end else if (wr_ctrl) begin
      write_allow_r <= bus.wdata[`FSRW_BIT_WEN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read sequence
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_bit_r <= 1'b0;
      rd_cnt_r <= '0;
    end else if (rd_bit_r) begin
      rd_cnt_r <= rd_cnt_r + 2'h1;
      if (rd_cnt_r == `FSRW_RD_DROP) begin
        rd_bit_r <= 1'b0;
        rd_cnt_r <= '0;
      end
    end else if (wr_ctrl && bus.wdata[`FSRW_BIT_RD]) begin
      rd_bit_r <= 1'b1;
    end
  end

  // the array is synchronous: fetch in the first cycle after the trigger so
  // the word lands as the second, dropped, instruction ends
  assign arr_rd        = rd_bit_r
                         && (rd_cnt_r == `FSRW_RD_FETCH);
  assign discard_instr = rd_bit_r
                         && (rd_cnt_r == `FSRW_RD_DROP);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_land_r <= 1'b0;
    end else begin
      rd_land_r <= arr_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write sequence
  fsrw_unlock u_unlock (
    .clk      (clk),
    .nrst     (nrst),
    .key_we   (wr_key),
    .other_we (bus.we && !wr_key && !wr_ctrl),
    .wdata    (bus.wdata),
    .unlocked (unlocked)
  );

  function automatic logic is_protected(input logic [`FSRW_AW-1:0] a,
                                        input logic [`FSRW_AW-1:0] lo,
                                        input logic [`FSRW_AW-1:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // protect enable comes from outside the clock domain: three flops, and a
  // change is taken once the second and third agree
  logic [2:0] prot_sync_r;
  logic       prot_en_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prot_sync_r <= '0;
    end else begin
      prot_sync_r <= {prot_sync_r[1:0], protect_en};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prot_en_r <= 1'b0;
    end else if (prot_sync_r[1] == prot_sync_r[2]) begin
      prot_en_r <= prot_sync_r[2];
    end
  end

  logic prot_hit;
  assign prot_hit = prot_en_r && is_protected(addr, protect_lo, protect_hi);

  assign wr_fire = wr_ctrl && bus.wdata[`FSRW_BIT_WR] && !wr_bit_r
                   && unlocked
                   && write_allow_r
                   && !prot_hit;

  logic [`FSRW_DW-1:0]   buf_r [0:3];
  logic [4*`FSRW_DW-1:0] buf_flat;
  logic                  last_word;
  logic [1:0]            setup_r;
  logic [31:0]           prog_cnt_r;
  logic [`FSRW_AW-1:0]   blk_addr_r;
  logic                  setup_end;
  logic                  prog_end;

  // buffer slot chosen by the two low address bits only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 4; i++) begin
        buf_r[i] <= '0;
      end
    end else if (wr_fire) begin
      buf_r[addr[1:0]] <= {data_high_reg_r, data_low_reg_r};
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      buf_flat[i*`FSRW_DW +: `FSRW_DW] = buf_r[i];
    end
  end

  // block address held from the trigger, so an address write during the
  // setup no-ops cannot move the erase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      blk_addr_r <= '0;
    end else if (wr_fire) begin
      blk_addr_r <= addr;
    end
  end

  assign last_word = (blk_addr_r[1:0] == `FSRW_LAST_OFS);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= fsrw_pkg::FSRW_IDLE;
    end else begin
      case (state_r)
        fsrw_pkg::FSRW_IDLE: begin
          if (wr_fire) begin
            state_r <= fsrw_pkg::FSRW_SETUP;
          end
        end
        // two setup cycles; the core runs the two no-ops meanwhile
        fsrw_pkg::FSRW_SETUP: begin
          if (setup_end) begin
            if (last_word) begin
              state_r <= fsrw_pkg::FSRW_PROG;
            end else begin
              state_r <= fsrw_pkg::FSRW_IDLE;
            end
          end
        end
        fsrw_pkg::FSRW_PROG: begin
          if (prog_end) begin
            state_r <= fsrw_pkg::FSRW_IDLE;
          end
        end
        default: begin
          state_r <= fsrw_pkg::FSRW_IDLE;
        end
      endcase
    end
  end

  // setup cycle count, held at zero outside the setup state
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      setup_r <= '0;
    end else if (state_r == fsrw_pkg::FSRW_SETUP) begin
      setup_r <= setup_r + 2'h1;
    end else begin
      setup_r <= '0;
    end
  end

  // halt cycle count, held at zero outside the halt
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prog_cnt_r <= '0;
    end else if (state_r == fsrw_pkg::FSRW_PROG) begin
      prog_cnt_r <= prog_cnt_r + 32'h0000_0001;
    end else begin
      prog_cnt_r <= '0;
    end
  end

  assign setup_end = (state_r == fsrw_pkg::FSRW_SETUP)
                     && (setup_r == `FSRW_SETUP_CYC - 2'h1);
  assign prog_end  = (state_r == fsrw_pkg::FSRW_PROG)
                     && (prog_cnt_r == 32'(PROG_CYC - 1));
  assign wr_done   = (setup_end && !last_word) || prog_end;

  // erase the 16-word row in the first halt cycle and program the block at its own base in the second
  assign erase = (state_r == fsrw_pkg::FSRW_PROG) && (prog_cnt_r == '0);
  assign prog  = (state_r == fsrw_pkg::FSRW_PROG)
                 && (prog_cnt_r == 32'h0000_0001);

  assign core_halt = (state_r == fsrw_pkg::FSRW_PROG);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_bit_r <= 1'b0;
    end else if (wr_fire) begin
      wr_bit_r <= 1'b1;
    end else if (wr_done) begin
      wr_bit_r <= 1'b0;
    end
  end

  fsrw_array u_array (
    .clk       (clk),
    .nrst      (nrst),
    .rd_addr   (addr),
    .rd_en     (arr_rd),
    .rd_data   (arr_rdata),
    .blk_addr  (blk_addr_r),
    .erase     (erase),
    .prog      (prog),
    .prog_data (buf_flat)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read port
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= '0;
    end else if (bus.re) begin
      case (bus.addr)
        `FSRW_OFS_CTRL:    rdata <= `FSRW_CTRL_TOP
                                    | {5'h00, write_allow_r, wr_bit_r,
                                       rd_bit_r};
        `FSRW_OFS_UNLOCK:  rdata <= '0;
        `FSRW_OFS_DATA_LO: rdata <= data_low_reg_r;
        `FSRW_OFS_DATA_HI: rdata <= {2'h0, data_high_reg_r};
        `FSRW_OFS_ADDR_LO: rdata <= addr_low_reg_r;
        `FSRW_OFS_ADDR_HI: rdata <= {5'h00, addr_high_reg_r};
        default:           rdata <= '0;
      endcase
    end else begin
      rdata <= '0;
    end
  end
endmodule

// >>> fsrw_ctrl_monitor.sv
// port checker for the flash self read/write controller
`include "fsrw_consts.svh"
module fsrw_ctrl_monitor #(
  parameter int PROG_CYC = 16
) (
  input wire logic                   clk,
  input wire logic                   nrst,
  input wire fsrw_pkg::fsrw_bus_type bus,
  input wire logic [7:0]             rdata,
  input wire logic                   discard_instr,
  input wire logic                   core_halt
);
  logic [31:0] halt_cnt_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      halt_cnt_r <= '0;
    else
      halt_cnt_r <= core_halt ? halt_cnt_r + 32'h1 : 32'h0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////
  a_rd_discard: assert property (
    discard_instr |-> $past(bus.we && bus.addr == `FSRW_OFS_CTRL &&
    bus.wdata[0], 2)) else $error("discard without read trigger");
  a_discard_one: assert property (
    discard_instr |=> !discard_instr) else $error("discard too long");
  a_rdata_idle: assert property (
    !$past(bus.re) |-> rdata == 8'h00) else $error("rdata not idle");
  a_unlock_zero: assert property (
    $past(bus.re && bus.addr == `FSRW_OFS_UNLOCK) |-> rdata == 8'h00)
    else $error("unlock port read not zero");
  a_ctrl_top: assert property (
    $past(bus.re && bus.addr == `FSRW_OFS_CTRL) |-> rdata[7:3] == 5'h10)
    else $error("control top bits wrong");
  a_data_hi_top: assert property (
    $past(bus.re && bus.addr == `FSRW_OFS_DATA_HI) |-> rdata[7:6] == 2'h0)
    else $error("data high top bits wrong");
  a_addr_hi_top: assert property (
    $past(bus.re && bus.addr == `FSRW_OFS_ADDR_HI) |-> rdata[7:3] == 5'h00)
    else $error("address high top bits wrong");
  a_halt_cause: assert property (
    $rose(core_halt) |-> $past(bus.we && bus.addr == `FSRW_OFS_CTRL &&
    bus.wdata[1], 3)) else $error("halt without write trigger");
  a_halt_len: assert property (
    $fell(core_halt) |-> halt_cnt_r == PROG_CYC)
    else $error("halt length wrong");
  a_halt_max: assert property (
    halt_cnt_r <= PROG_CYC) else $error("halt too long");
endmodule
bind fsrw_ctrl fsrw_ctrl_monitor #(.PROG_CYC(PROG_CYC)) u_mon (
  .clk           (clk),
  .nrst          (nrst),
  .bus           (bus),
  .rdata         (rdata),
  .discard_instr (discard_instr),
  .core_halt     (core_halt)
);

// >>> fsrw_core_model.sv
// processor core model issuing register accesses to the controller
`include "fsrw_consts.svh"
module fsrw_core_model (
  input  wire logic              clk,
  input  wire logic [7:0]        rdata,
  output fsrw_pkg::fsrw_bus_type bus
);
  initial bus = '0;
  // idle cycles show inverted address; write idles also invert the data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk);
    bus <= '{addr: ~a, wdata: ~d, we: 1'b0, re: 1'b0};
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    bus <= '{addr: a, wdata: ~bus.wdata, we: 1'b0, re: 1'b1};
    @(posedge clk);
    bus <= '{addr: ~a, wdata: bus.wdata, we: 1'b0, re: 1'b0};
    @(posedge clk);
    d = rdata;
  endtask
  task automatic set_addr(input logic [10:0] a);
    wr(`FSRW_OFS_ADDR_HI, {5'h00, a[10:8]});
    wr(`FSRW_OFS_ADDR_LO, a[7:0]);
  endtask
  task automatic write_word(input logic [10:0] a, input logic [13:0] d,
                            input logic [7:0] k1, input logic [7:0] k2);
    set_addr(a);
    wr(`FSRW_OFS_DATA_LO, d[7:0]);
    wr(`FSRW_OFS_DATA_HI, {2'h0, d[13:8]});
    wr(`FSRW_OFS_UNLOCK, k1);
    wr(`FSRW_OFS_UNLOCK, k2);
    wr(`FSRW_OFS_CTRL, 8'h06);
    // the idle slot after the trigger is the first no-op
    repeat (1) @(posedge clk);
  endtask
  task automatic read_word(input logic [10:0] a, output logic [13:0] d);
    logic [7:0] lo;
    logic [7:0] hi;
    set_addr(a);
    wr(`FSRW_OFS_CTRL, 8'h01);
    @(posedge clk);
    rd(`FSRW_OFS_DATA_LO, lo);
    rd(`FSRW_OFS_DATA_HI, hi);
    d = {hi[5:0], lo};
  endtask
endmodule

// >>> testbench.sv
// self-checking bench for the flash self read/write controller
`include "fsrw_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                   clk;
  logic                   nrst;
  fsrw_pkg::fsrw_bus_type bus;
  logic [7:0]             rdata;
  logic [10:0]            protect_lo;
  logic [10:0]            protect_hi;
  logic                   protect_en;
  logic                   discard_instr;
  logic                   core_halt;
  int                     failures;
  int                     n_tests;
  fsrw_ctrl #(.PROG_CYC(16)) DUT (
    .clk           (clk),
    .nrst          (nrst),
    .bus           (bus),
    .rdata         (rdata),
    .protect_lo    (protect_lo),
    .protect_hi    (protect_hi),
    .protect_en    (protect_en),
    .discard_instr (discard_instr),
    .core_halt     (core_halt)
  );
  fsrw_core_model core (
    .clk   (clk),
    .rdata (rdata),
    .bus   (bus)
  );
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    if (failures == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // counts halted cycles while the core waits to resume
  task automatic halt_cycles(output int n);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      if (core_halt === 1'b1)
        n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic s_reset;
    logic [7:0] a [7];
    logic [7:0] e [7];
    logic [7:0] d;
    a = '{8'h93, 8'h94, 8'h95, 8'h96, 8'h97, 8'h98, 8'h99};
    e = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 7; i++) begin
      core.rd(a[i], d);
      chk(d, e[i]);
    end
    core.wr(`FSRW_OFS_ADDR_HI, 8'hFF);
    core.rd(`FSRW_OFS_ADDR_HI, d);
    chk(d, 8'h07);
    core.wr(`FSRW_OFS_DATA_HI, 8'hFF);
    core.rd(`FSRW_OFS_DATA_HI, d);
    chk(d, 8'h3F);
    core.wr(`FSRW_OFS_UNLOCK, 8'h55);
    core.rd(`FSRW_OFS_UNLOCK, d);
    chk(d, 8'h00);
    core.wr(`FSRW_OFS_CTRL, 8'hF8);
    core.rd(`FSRW_OFS_CTRL, d);
    chk(d, 8'h80);
  endtask
  task automatic s_block;
    int         n;
    logic [7:0] d;
    logic [13:0] w;
    core.wr(`FSRW_OFS_CTRL, 8'h04);
    for (int i = 0; i < 4; i++) begin
      core.write_word(11'h010 + 11'(i), 14'h3A50 | 14'(i), 8'h55, 8'hAA);
      halt_cycles(n);
      chk(14'(n), (i == 3) ? 14'h0010 : 14'h0000);
      core.rd(`FSRW_OFS_CTRL, d);
      chk(d, 8'h84);
    end
    for (int i = 0; i < 5; i++) begin
      core.read_word(11'h010 + 11'(i), w);
      chk(w, (i < 4) ? (14'h3A50 | 14'(i)) : 14'h3FFF);
    end
    core.read_word(11'h01F, w);
    chk(w, 14'h3FFF);
  endtask
  task automatic s_refused;
    int          n;
    logic [7:0]  d;
    logic [13:0] w;
    logic [7:0]  k1;
    for (int c = 0; c < 3; c++) begin
      core.wr(`FSRW_OFS_CTRL, (c == 0) ? 8'h00 : 8'h04);
      k1 = (c == 1) ? 8'hAA : 8'h55;
      protect_en <= (c == 2);
      core.write_word(11'h013, 14'h0123, k1, ~k1);
      halt_cycles(n);
      chk(14'(n), 14'h0000);
      core.rd(`FSRW_OFS_CTRL, d);
      chk(d, 8'h84);
      core.read_word(11'h013, w);
      chk(w, 14'h3A53);
    end
  endtask
  task automatic s_partial;
    int          n;
    logic [13:0] w;
    logic [13:0] e;
    protect_en <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      w = 14'h0155;
      if (i != 1)
        core.read_word(11'h010 + 11'(i), w);
      core.wr(`FSRW_OFS_CTRL, 8'h04);
      core.write_word(11'h010 + 11'(i), w, 8'h55, 8'hAA);
      halt_cycles(n);
      chk(14'(n), (i == 3) ? 14'h0010 : 14'h0000);
    end
    for (int i = 0; i < 5; i++) begin
      e = (i == 1) ? 14'h0155 : (i < 4) ? (14'h3A50 | 14'(i)) : 14'h3FFF;
      core.read_word(11'h010 + 11'(i), w);
      chk(w, e);
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #800000;
    failures++;
    finish_test();
  end
  initial begin
    failures = 0;
    n_tests = 0;
    nrst = 1'b0;
    protect_lo = 11'h010;
    protect_hi = 11'h013;
    protect_en = 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    s_reset();
    s_block();
    s_refused();
    s_partial();
    finish_test();
  end
endmodule
